//--- rtl/sts_sequencer.sv
// Scan sequencer driven by the external control port trigger inputs.
// Operation
// - Advance edge starts scan or steps channel.
// - Next advance edge ends the closed pulse.
// - Advance edges ignored until pulse is issued.
// - Abort input stops scan, opens relay.
// - After abort, next advance restarts first channel.
// - Wait 5 ms settling after relay opens.
// - Wait 5 ms settling after relay closes.
// - Insert user channel delay 0 to 9999 ms.
// - Closed pulse width programmable 1 to 100 ms.
// - Sinking mode inverts advance and abort pin logic levels.
// - Fixed or user comm settings; fixed default.
// - Closed pulse ends when relay opens.
// - Abort opens every channel relay.
`timescale 1ns/10ps
module sts_sequencer #(
  parameter int unsigned MS_CYCLES = sts_pkg::MS_CYCLES
) (
  input  wire logic                          ref_clk,
  input  wire logic                          sys_rst,
  input  wire logic                          scan_advance_pin,
  input  wire logic                          scan_abort_pin,
  input  wire logic                          sink_mode,
  input  wire logic                          comm_user_sel_pin,
  input  wire logic [sts_pkg::MS_W-1:0]      chan_delay_ms,
  input  wire logic [sts_pkg::PULSE_W-1:0]   pulse_width_ms,
  input  wire logic [sts_pkg::CH_W-1:0]      scan_last_ch,
  output logic      [sts_pkg::NUM_CH-1:0]    relay_close_q,
  output logic      [sts_pkg::CH_W-1:0]      chan_idx_q,
  output logic                               close_pulse_q,
  output logic                               scan_active_q,
  output logic                               busy_q,
  output logic                               fixed_comm_settings_q
);

  // Limits a millisecond setting to its legal range.
  function automatic logic [13:0] clamp_ms(input logic [13:0] val,
                                           input logic [13:0] lo,
                                           input logic [13:0] hi);
    logic [13:0] res;
    res = val;
    if (val < lo) begin
      res = lo;
    end else if (val > hi) begin
      res = hi;
    end
    return res;
  endfunction : clamp_ms

  // Last prescaler value of each millisecond.
  localparam logic [sts_pkg::PRESC_W-1:0] PRESC_LAST = sts_pkg::PRESC_W'(MS_CYCLES - 1);

  // Raw pins, their inversion modes and the synchronised results.
  logic [sts_pkg::NUM_IN-1:0] pin_vec;
  logic [sts_pkg::NUM_IN-1:0] inv_vec;
  logic [sts_pkg::NUM_IN-1:0] lvl_vec;
  logic [sts_pkg::NUM_IN-1:0] rise_vec;
  // Sequencer state and next state.
  sts_pkg::sts_state_t state_q;
  sts_pkg::sts_state_t state_d;
  // Wait counter load request and value.
  logic                       wait_load;
  logic [sts_pkg::MS_W-1:0]   wait_val;
  // Remaining milliseconds of the current wait and its prescaler.
  logic [sts_pkg::MS_W-1:0]   wait_ms_q;
  logic [sts_pkg::PRESC_W-1:0] wait_presc_q;
  // Remaining pulse milliseconds and its own prescaler.
  logic [sts_pkg::MS_W-1:0]   pulse_ms_q;
  logic [sts_pkg::PRESC_W-1:0] pulse_presc_q;
  // Derived events.
  logic adv_evt;
  logic abort_evt;
  logic wait_done;
  logic close_go;
  logic relay_opening;
  logic pulse_start;
  logic [sts_pkg::CH_W-1:0] next_idx;

  assign pin_vec[sts_pkg::IN_ADVANCE] = scan_advance_pin;
  assign pin_vec[sts_pkg::IN_ABORT]   = scan_abort_pin;
  assign pin_vec[sts_pkg::IN_COMM]    = comm_user_sel_pin;
  assign inv_vec[sts_pkg::IN_ADVANCE] = sink_mode;
  assign inv_vec[sts_pkg::IN_ABORT]   = sink_mode;
  // The selector switch is a plain contact, not an isolated trigger line.
  assign inv_vec[sts_pkg::IN_COMM]    = 1'b0;

  // One synchroniser per asynchronous input.
  genvar gi;
  generate
    for (gi = 0; gi < sts_pkg::NUM_IN; gi++) begin : g_sync
      sts_edge_sync u_sync (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .pin_in  (pin_vec[gi]),
        .invert  (inv_vec[gi]),
        .level_q (lvl_vec[gi]),
        .rise_q  (rise_vec[gi])
      );
    end
  endgenerate

  // Trigger inputs are sampled every cycle, so any pulse the far side
  // holds for a millisecond or more is seen many times over.
  // advance recognised
  assign adv_evt   = rise_vec[sts_pkg::IN_ADVANCE];
  assign abort_evt = rise_vec[sts_pkg::IN_ABORT];
  assign wait_done = (wait_ms_q == '0);

  // Next-state logic; advances are honoured only in idle and hold.
  always_comb begin
    state_d   = state_q;
    wait_load = 1'b0;
    wait_val  = '0;
    case (state_q)
      sts_pkg::STS_IDLE: begin
        if (adv_evt) begin
          state_d   = sts_pkg::STS_CLOSE_WAIT;
          wait_load = 1'b1;
          wait_val  = sts_pkg::CLOSE_SETTLE_MS;
        end
      end
      sts_pkg::STS_HOLD: begin
        if (adv_evt) begin
          state_d   = sts_pkg::STS_OPEN_WAIT;
          wait_load = 1'b1;
          wait_val  = sts_pkg::OPEN_SETTLE_MS;
        end
      end
      sts_pkg::STS_OPEN_WAIT: begin
        if (wait_done) begin
          if (chan_idx_q == scan_last_ch) begin
            // Past the last channel the scan ends with all relays open.
            state_d = sts_pkg::STS_IDLE;
          end else begin
            state_d   = sts_pkg::STS_CLOSE_WAIT;
            wait_load = 1'b1;
            wait_val  = sts_pkg::CLOSE_SETTLE_MS;
          end
        end
      end
      sts_pkg::STS_CLOSE_WAIT: begin
        if (wait_done) begin
          state_d   = sts_pkg::STS_DELAY;
          wait_load = 1'b1;
          wait_val  = clamp_ms(chan_delay_ms, sts_pkg::CHAN_DELAY_MIN_MS,
                               sts_pkg::CHAN_DELAY_MAX_MS);
        end
      end
      sts_pkg::STS_DELAY: begin
        if (wait_done) begin
          state_d = sts_pkg::STS_HOLD;
        end
      end
      default: begin
        state_d = sts_pkg::STS_IDLE;
      end
    endcase
    if (abort_evt) begin
      state_d   = sts_pkg::STS_IDLE;
      wait_load = 1'b0;
    end
  end

  assign close_go      = (state_d == sts_pkg::STS_CLOSE_WAIT) &&
                         (state_q != sts_pkg::STS_CLOSE_WAIT);
  assign relay_opening = (state_q == sts_pkg::STS_HOLD) && (state_d != sts_pkg::STS_HOLD);
  assign pulse_start   = (state_q == sts_pkg::STS_DELAY) && (state_d == sts_pkg::STS_HOLD);
  assign next_idx      = (state_q == sts_pkg::STS_IDLE) ? '0 : chan_idx_q + 1'b1;

  // Sequence state, channel index and scan flag.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_q       <= sts_pkg::STS_IDLE;
      chan_idx_q    <= '0;
      scan_active_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (abort_evt) begin
        chan_idx_q    <= '0;
        scan_active_q <= 1'b0;
      end else if (close_go) begin
        chan_idx_q    <= next_idx;
        scan_active_q <= 1'b1;
      end else if (state_d == sts_pkg::STS_IDLE) begin
        chan_idx_q    <= '0;
        scan_active_q <= 1'b0;
      end
    end
  end

  // Relay drive; opening always comes before the next close.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      relay_close_q <= '0;
    end else if (abort_evt) begin
      relay_close_q <= '0;
    end else if (relay_opening) begin
      relay_close_q <= '0;
    end else if (close_go) begin
      relay_close_q <= sts_pkg::NUM_CH'(1) << next_idx;
    end
  end

  // Wait counter; the prescaler restarts on each load so a wait is never
  // shortened by a partly elapsed millisecond.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wait_ms_q    <= '0;
      wait_presc_q <= '0;
    end else if (wait_load) begin
      wait_ms_q    <= wait_val;
      wait_presc_q <= '0;
    end else if (abort_evt) begin
      wait_ms_q    <= '0;
      wait_presc_q <= '0;
    end else if (!wait_done) begin
      if (wait_presc_q == PRESC_LAST) begin
        wait_presc_q <= '0;
        wait_ms_q    <= wait_ms_q - 1'b1;
      end else begin
        wait_presc_q <= wait_presc_q + 1'b1;
      end
    end
  end

  // Channel-closed pulse with its own timer.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      close_pulse_q <= 1'b0;
      pulse_ms_q    <= '0;
      pulse_presc_q <= '0;
    end else if (pulse_start) begin
      close_pulse_q <= 1'b1;
      pulse_ms_q    <= clamp_ms({7'h00, pulse_width_ms}, sts_pkg::PULSE_MIN_MS,
                                sts_pkg::PULSE_MAX_MS);
      pulse_presc_q <= '0;
    end else if (close_pulse_q) begin
      if (relay_opening || abort_evt) begin
        close_pulse_q <= 1'b0;
      end else if (close_go) begin
        close_pulse_q <= 1'b0;
      end else if (pulse_presc_q == PRESC_LAST) begin
        pulse_presc_q <= '0;
        pulse_ms_q    <= pulse_ms_q - 1'b1;
        if (pulse_ms_q == 14'h0001) begin
          close_pulse_q <= 1'b0;
        end
      end else begin
        pulse_presc_q <= pulse_presc_q + 1'b1;
      end
    end
  end

  // Busy while a channel switch is under way.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= (state_d == sts_pkg::STS_OPEN_WAIT) ||
                (state_d == sts_pkg::STS_CLOSE_WAIT) ||
                (state_d == sts_pkg::STS_DELAY);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      fixed_comm_settings_q <= 1'b1;
    end else begin
      fixed_comm_settings_q <= ~lvl_vec[sts_pkg::IN_COMM];
    end
  end

endmodule : sts_sequencer

//--- rtl/sts_pkg.sv
// Shared constants for the scan trigger sequencer.
package sts_pkg;

  // Clock period of ref_clk in nanoseconds (40 MHz).
  localparam int unsigned CLK_PERIOD_NS = 32'h0000_0019;
  // One millisecond expressed in nanoseconds.
  localparam int unsigned MS_NS = 32'h000F_4240;
  // Clock cycles per millisecond tick, rounded up.
  localparam int unsigned MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Width of the millisecond prescaler.
  localparam int unsigned PRESC_W = 32'h0000_0010;

  // Number of channel relays and the width of a channel index.
  localparam int unsigned NUM_CH = 32'h0000_0010;
  localparam int unsigned CH_W = 32'h0000_0004;

  // Width of the millisecond wait counter (holds up to 9999).
  localparam int unsigned MS_W = 32'h0000_000E;
  // Width of the pulse width setting (holds up to 100).
  localparam int unsigned PULSE_W = 32'h0000_0007;

  // Relay settling after opening and after closing, in milliseconds.
  localparam logic [13:0] OPEN_SETTLE_MS = 14'h0005;
  localparam logic [13:0] CLOSE_SETTLE_MS = 14'h0005;
  // Range of the user channel delay, in milliseconds.
  localparam logic [13:0] CHAN_DELAY_MIN_MS = 14'h0000;
  localparam logic [13:0] CHAN_DELAY_MAX_MS = 14'h270F;
  // Range of the channel-closed pulse width, in milliseconds.
  localparam logic [13:0] PULSE_MIN_MS = 14'h0001;
  localparam logic [13:0] PULSE_MAX_MS = 14'h0064;
  // Least width the far side must give either trigger input, in milliseconds.
  localparam int unsigned MIN_INPUT_PULSE_MS = 32'h0000_0001;

  // Index of each synchronised input.
  localparam int unsigned IN_ADVANCE = 32'h0000_0000;
  localparam int unsigned IN_ABORT = 32'h0000_0001;
  localparam int unsigned IN_COMM = 32'h0000_0002;
  localparam int unsigned NUM_IN = 32'h0000_0003;

  // Sequencer states.
  typedef enum logic [2:0] {
    STS_IDLE,
    STS_OPEN_WAIT,
    STS_CLOSE_WAIT,
    STS_DELAY,
    STS_HOLD
  } sts_state_t;

endpackage : sts_pkg

//--- rtl/sts_edge_sync.sv
// Three-stage input synchroniser with polarity and rising-edge detection.
`timescale 1ns/10ps
module sts_edge_sync (
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic pin_in,
  input  wire logic invert,
  output logic      level_q,
  output logic      rise_q
);

  // Synchroniser chain; stage one feeds only stage two.
  logic sync1_q;
  logic sync2_q;
  logic sync3_q;
  // Accepted raw level once stages two and three agree.
  logic stable_q;
  // Logical level after the polarity mode is applied.
  logic logic_lvl;

  // The chain samples the asynchronous pin. Reset fills it with the idle
  // terminal level of the selected polarity mode, so that the logical level
  // is low from the first edge and no false edge follows reset.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sync1_q <= invert;
      sync2_q <= invert;
      sync3_q <= invert;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // A change is taken only when the two later stages agree, so one
  // metastable sample cannot produce a false edge.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      stable_q <= invert;
    end else if (sync2_q == sync3_q) begin
      stable_q <= sync2_q;
    end
  end

  // Sinking mode inverts the terminal level.
  assign logic_lvl = stable_q ^ invert;

  // Level and single-cycle rising edge of the logical signal.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      level_q <= 1'b0;
      rise_q  <= 1'b0;
    end else begin
      level_q <= logic_lvl;
      rise_q  <= logic_lvl & ~level_q;
    end
  end

endmodule : sts_edge_sync

//--- sim/sts_sequencer_monitor.sv
// Concurrent checks on the ports of the scan trigger sequencer.
`timescale 1ns/10ps
module sts_sequencer_monitor #(
  parameter int unsigned MS_CYCLES = sts_pkg::MS_CYCLES
) (
  input wire logic                        ref_clk,
  input wire logic                        sys_rst,
  input wire logic                        scan_advance_pin,
  input wire logic                        scan_abort_pin,
  input wire logic                        sink_mode,
  input wire logic                        comm_user_sel_pin,
  input wire logic [sts_pkg::MS_W-1:0]    chan_delay_ms,
  input wire logic [sts_pkg::PULSE_W-1:0] pulse_width_ms,
  input wire logic [sts_pkg::CH_W-1:0]    scan_last_ch,
  input wire logic [sts_pkg::NUM_CH-1:0]  relay_close_q,
  input wire logic [sts_pkg::CH_W-1:0]    chan_idx_q,
  input wire logic                        close_pulse_q,
  input wire logic                        scan_active_q,
  input wire logic                        busy_q,
  input wire logic                        fixed_comm_settings_q
);
  // Relay settling in cycles.
  localparam int unsigned SETTLE = int'(sts_pkg::OPEN_SETTLE_MS) * MS_CYCLES;
  logic [31:0] pw_ms;        // Pulse width setting after the legal range is applied.
  logic [31:0] open_cnt_q;   // Cycles with every relay open in mid-switch.
  logic [31:0] close_cnt_q;  // Cycles a closed relay has waited for its pulse.
  logic [31:0] width_cnt_q;  // Cycles the closed pulse has stood high.
  logic [31:0] dly_cyc;      // Expected wait from relay close to pulse.
  logic [31:0] pw_cyc;       // Expected pulse length.
  // The settings are held steady by the bench, so they are read live here.
  assign dly_cyc = (32'(chan_delay_ms) + 32'(sts_pkg::CLOSE_SETTLE_MS)) * MS_CYCLES;
  // Out-of-range widths are limited to the legal range.
  assign pw_ms   = (32'(pulse_width_ms) < 32'(sts_pkg::PULSE_MIN_MS)) ?
                   32'(sts_pkg::PULSE_MIN_MS) :
                   (32'(pulse_width_ms) > 32'(sts_pkg::PULSE_MAX_MS)) ?
                   32'(sts_pkg::PULSE_MAX_MS) : 32'(pulse_width_ms);
  assign pw_cyc  = pw_ms * MS_CYCLES;
  // Each counter restarts whenever its phase of the sequence is left.
  always_ff @(posedge ref_clk) begin
    open_cnt_q <= (sys_rst || !busy_q || relay_close_q != '0) ? '0 : open_cnt_q + 32'd1;
  end
  always_ff @(posedge ref_clk) begin
    close_cnt_q <= (sys_rst || !busy_q || relay_close_q == '0) ? '0 : close_cnt_q + 32'd1;
  end
  always_ff @(posedge ref_clk) begin
    width_cnt_q <= (sys_rst || !close_pulse_q) ? '0 : width_cnt_q + 32'd1;
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  sequence s_pulse_start;
    $rose(close_pulse_q);
  endsequence
  // A pulse that ends with no relay change has run its full width.
  sequence s_pulse_lapse;
    $fell(close_pulse_q) && !$changed(relay_close_q);
  endsequence
  sequence s_comm_steady;
    $stable(comm_user_sel_pin) [*8];
  endsequence
  chk_relay_onehot: assert property ($onehot0(relay_close_q) &&
    (relay_close_q == '0 || relay_close_q[chan_idx_q])) else $error("Relay drive wrong.");
  chk_idle_open: assert property (!scan_active_q |->
    relay_close_q == '0 && !busy_q && !close_pulse_q) else $error("Idle with relay closed.");
  chk_start_first: assert property ($rose(scan_active_q) |-> chan_idx_q == '0 &&
    relay_close_q == 16'h0001 && busy_q) else $error("Scan did not start at first channel.");
  chk_pulse_closed: assert property (close_pulse_q |->
    !busy_q && relay_close_q != '0) else $error("Pulse without closed relay.");
  chk_pulse_cut: assert property ($changed(relay_close_q) |-> !close_pulse_q)
    else $error("Pulse stood across relay change.");
  chk_open_settle: assert property (($past(relay_close_q) == '0 &&
    relay_close_q != '0 && $past(busy_q)) |-> open_cnt_q >= SETTLE && open_cnt_q <= SETTLE + 3)
    else $error("Open settling time wrong.");
  chk_close_delay: assert property (s_pulse_start |-> $fell(busy_q) &&
    close_cnt_q >= dly_cyc && close_cnt_q <= dly_cyc + 3) else $error("Close delay wrong.");
  chk_pulse_width: assert property (s_pulse_lapse |->
    width_cnt_q >= pw_cyc && width_cnt_q <= pw_cyc + 1) else $error("Pulse width wrong.");
  chk_comm_mode: assert property (s_comm_steady |->
    fixed_comm_settings_q == !comm_user_sel_pin) else $error("Comm mode wrong.");
  // The scan never runs past its last channel; settings change only while idle.
  chk_idx_bound: assert property (scan_active_q |->
    chan_idx_q <= scan_last_ch) else $error("Channel beyond scan end.");
endmodule : sts_sequencer_monitor

bind sts_sequencer sts_sequencer_monitor #(.MS_CYCLES(MS_CYCLES)) mon_u (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .scan_advance_pin(scan_advance_pin),
  .scan_abort_pin(scan_abort_pin), .sink_mode(sink_mode), .comm_user_sel_pin(comm_user_sel_pin),
  .chan_delay_ms(chan_delay_ms), .pulse_width_ms(pulse_width_ms), .scan_last_ch(scan_last_ch),
  .relay_close_q(relay_close_q), .chan_idx_q(chan_idx_q), .close_pulse_q(close_pulse_q),
  .scan_active_q(scan_active_q), .busy_q(busy_q),
  .fixed_comm_settings_q(fixed_comm_settings_q)
);

//--- sim/sts_plc_model.sv
// Far-side controller model that pulses the scan trigger pins.
`timescale 1ns/10ps
module sts_plc_model #(
  parameter int unsigned MS_CYCLES = 10
) (
  input  wire logic ref_clk,
  input  wire logic sink_mode,
  output logic      scan_advance_pin,
  output logic      scan_abort_pin
);
  logic adv_q;  // Logical advance level.
  logic abt_q;  // Logical abort level.
  initial begin
    adv_q = 1'b0;
    abt_q = 1'b0;
  end
  // pin polarity
  // Sinking mode inverts the terminal level for each logical state.
  assign scan_advance_pin = adv_q ^ sink_mode;
  assign scan_abort_pin   = abt_q ^ sink_mode;
  // minimum width
  // Pulses last twice the least width so no sampling phase can miss them.
  task automatic pulse(input logic abort);
    @(posedge ref_clk);
    if (abort) begin
      abt_q <= 1'b1;
    end else begin
      adv_q <= 1'b1;
    end
    repeat (2 * MS_CYCLES) @(posedge ref_clk);
    abt_q <= 1'b0;
    adv_q <= 1'b0;
    // Hold the idle level as well, so that back-to-back pulses are not merged
    // by the input filter of the device.
    repeat (MS_CYCLES) @(posedge ref_clk);
    #1;
  endtask : pulse
endmodule : sts_plc_model

//--- sim/sts_sequencer_tb.sv
// Self-checking bench for the scan trigger sequencer.
`timescale 1ns/10ps
module sts_sequencer_tb;
  localparam int unsigned MSC = 10;  // Shortened millisecond, in cycles.
  localparam int unsigned PW  = 5;   // Pulse width setting in ms.
  logic                          ref_clk;
  logic                          sys_rst;
  logic                          sink_mode;
  logic                          comm_user_sel_pin;
  logic [sts_pkg::MS_W-1:0]      chan_delay_ms;
  logic [sts_pkg::PULSE_W-1:0]   pulse_width_ms;
  logic [sts_pkg::CH_W-1:0]      scan_last_ch;
  logic                          scan_advance_pin;
  logic                          scan_abort_pin;
  logic [sts_pkg::NUM_CH-1:0]    relay_close_q;
  logic [sts_pkg::CH_W-1:0]      chan_idx_q;
  logic                          close_pulse_q;
  logic                          scan_active_q;
  logic                          busy_q;
  logic                          fixed_comm_settings_q;
  int                            fail_count;
  int                            n_tests;
  int                            cyc;
  sts_sequencer #(.MS_CYCLES(MSC)) dut_u (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .scan_advance_pin(scan_advance_pin),
    .scan_abort_pin(scan_abort_pin), .sink_mode(sink_mode), .comm_user_sel_pin(comm_user_sel_pin),
    .chan_delay_ms(chan_delay_ms), .pulse_width_ms(pulse_width_ms), .scan_last_ch(scan_last_ch),
    .relay_close_q(relay_close_q), .chan_idx_q(chan_idx_q), .close_pulse_q(close_pulse_q),
    .scan_active_q(scan_active_q), .busy_q(busy_q),
    .fixed_comm_settings_q(fixed_comm_settings_q)
  );
  sts_plc_model #(.MS_CYCLES(MSC)) plc_u (
    .ref_clk(ref_clk), .sink_mode(sink_mode),
    .scan_advance_pin(scan_advance_pin), .scan_abort_pin(scan_abort_pin)
  );
  // The clock toggles every half period of 12.5 ns.
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic finish_test();
    if (fail_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test
  // A hung handshake would stall the run, so a cycle ceiling cuts it short.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      fail_count++;
      finish_test();
    end
  end
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  // Waits, bounded, for the closed pulse and returns just after the edge that shows it.
  task automatic wait_pulse();
    int n;
    n = 0;
    #1;
    while (close_pulse_q !== 1'b1 && n < 2000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
  endtask : wait_pulse
  task automatic t_comm();
    for (int i = 1; i >= 0; i--) begin
      @(posedge ref_clk);
      comm_user_sel_pin <= i[0];
      repeat (8) @(posedge ref_clk);
      #1;
      check("fixed_comm", 16'(!i[0]), 16'(fixed_comm_settings_q));
    end
  endtask : t_comm
  // Full scan of two channels with an early advance and a cut pulse.
  task automatic t_scan();
    int n;
    plc_u.pulse(1'b0);
    check("relay_first", 16'h0001, relay_close_q);
    plc_u.pulse(1'b0);
    wait_pulse();
    check("chan_ignored", 16'h0000, 16'(chan_idx_q));
    n = 0;
    while (close_pulse_q === 1'b1 && n < 200) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check("pulse_width", 16'(PW * MSC), 16'(n));
    plc_u.pulse(1'b0);
    check("relay_open", 16'h0000, relay_close_q);
    wait_pulse();
    check("relay_next", 16'h0002, relay_close_q);
    plc_u.pulse(1'b0);
    check("pulse_cut", 16'h0000, 16'(close_pulse_q));
    repeat (6 * MSC) @(posedge ref_clk);
    #1;
    check("scan_end", 16'h0000, 16'(scan_active_q));
  endtask : t_scan
  // Single-channel scans at the setting limits: clamped width, short delays.
  task automatic t_limits(input logic [13:0] dly, input logic [6:0] width, input int exp_w);
    int n;
    @(posedge ref_clk);
    chan_delay_ms  <= dly;
    pulse_width_ms <= width;
    scan_last_ch   <= '0;
    plc_u.pulse(1'b0);
    wait_pulse();
    check("single_relay", 16'h0001, relay_close_q);
    n = 0;
    while (close_pulse_q === 1'b1 && n < 1200) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check("pulse_clamp", 16'(exp_w), 16'(n));
    plc_u.pulse(1'b0);
    repeat (6 * MSC) @(posedge ref_clk);
    #1;
    check("single_end", 16'h0000, 16'(scan_active_q));
  endtask : t_limits
  // Aborts in mid-switch and with a pulse standing, then restarts.
  task automatic t_abort();
    plc_u.pulse(1'b0);
    plc_u.pulse(1'b1);
    check("abort_busy", 16'h0000, 16'(scan_active_q));
    plc_u.pulse(1'b0);
    wait_pulse();
    plc_u.pulse(1'b0);
    wait_pulse();
    plc_u.pulse(1'b1);
    check("abort_relays", 16'h0000, relay_close_q);
    check("abort_pulse", 16'h0000, 16'(close_pulse_q));
    plc_u.pulse(1'b0);
    check("restart_relay", 16'h0001, relay_close_q);
    plc_u.pulse(1'b1);
  endtask : t_abort
  // Sinking mode under a mid-run reset: inverted pin levels still work.
  task automatic t_sink();
    @(posedge ref_clk);
    sys_rst   <= 1'b1;
    sink_mode <= 1'b1;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    plc_u.pulse(1'b0);
    check("sink_start", 16'h0001, 16'(scan_active_q));
    plc_u.pulse(1'b1);
    check("sink_abort", 16'h0000, 16'(scan_active_q));
  endtask : t_sink
  initial begin
    sys_rst           = 1'b1;
    sink_mode         = 1'b0;
    comm_user_sel_pin = 1'b0;
    chan_delay_ms     = 14'h0001;
    pulse_width_ms    = 7'(PW);
    scan_last_ch      = 4'h1;
    fail_count        = 0;
    n_tests           = 0;
    cyc               = 0;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    check("fixed_reset", 16'h0001, 16'(fixed_comm_settings_q));
    t_comm();
    t_scan();
    t_abort();
    t_limits(14'h0000, 7'h00, int'(sts_pkg::PULSE_MIN_MS) * MSC);
    t_limits(14'h0002, 7'h7F, int'(sts_pkg::PULSE_MAX_MS) * MSC);
    t_sink();
    finish_test();
  end
endmodule : sts_sequencer_tb
